/* File: include/iwec_cfg.svh */
// register offsets, field positions, reset values for the input word checker
// assumes an 8-bit register port with 7-bit byte addresses
`ifndef IWEC_CFG_SVH
`define IWEC_CFG_SVH

`define IWEC_ADDR_CTRL     7'h60
`define IWEC_ADDR_S0_LO    7'h61
`define IWEC_ADDR_S0_HI    7'h62
`define IWEC_ADDR_S1_LO    7'h63
`define IWEC_ADDR_S1_HI    7'h64
`define IWEC_ADDR_S2_LO    7'h65
`define IWEC_ADDR_S2_HI    7'h66
`define IWEC_ADDR_S3_LO    7'h67
`define IWEC_ADDR_S3_HI    7'h68
`define IWEC_ADDR_PCTRL    7'h6a
`define IWEC_ADDR_RCNT     7'h6b
`define IWEC_ADDR_FCNT     7'h6c
`define IWEC_ADDR_REV      7'h7f

`define IWEC_BIT_CMP_EN    7
`define IWEC_BIT_CMP_CLR   6
`define IWEC_BIT_AUTO_EN   5
`define IWEC_BIT_DEPTH     4
`define IWEC_BIT_PASS      2
`define IWEC_BIT_FAIL      1
`define IWEC_BIT_MISM      0

`define IWEC_BIT_PAR_EN    7
`define IWEC_BIT_PAR_EVEN  6
`define IWEC_BIT_PAR_CLR   5
`define IWEC_BIT_FALL_ERR  1
`define IWEC_BIT_RISE_ERR  0

`define IWEC_RESET_BYTE    8'h00
`define IWEC_PASS_SETS     4'h8
`define IWEC_CNT_CLIP      8'hff
// slot 2/3 high bytes hold only three bits
`define IWEC_HI_MASK       8'h07
// arbitrary neutral revision value
`define IWEC_REVISION      8'h5a

`endif

/* File: include/iwec_pkg.sv */
// types for the input word checker
// assumes nothing outside itself
package iwec_pkg;

	typedef enum logic [1:0] {
		IWEC_SLOT0 = 2'h0,
		IWEC_SLOT1 = 2'h1,
		IWEC_SLOT2 = 2'h3,
		IWEC_SLOT3 = 2'h2
	} iwec_slot_t;

	typedef struct packed {
		logic [7:0]       ctrl;
		logic [7:0][7:0]  patt;
		logic [7:0]       pctrl;
		logic [7:0]       rise_cnt;
		logic [7:0]       fall_cnt;
		iwec_slot_t       slot;
		logic [3:0]       good_sets;
		logic             set_bad;
		logic [7:0]       rd_data;
	} iwec_state_t;

endpackage : iwec_pkg

/* File: design/iwec_checker.sv */
// input word checker: pattern comparator and parity counter
// assumes sample words already captured into clk; rising/falling words
// arrive tagged by word_fall, one per word_valid, in slot order
//
// How it works
// R1 - compare only while compare enable set
// R2 - compare clear wipes pass, fail, mismatch
// R3 - auto mode clears errors after eight sets
// R4 - depth bit picks two or four words
// R5 - auto pass after eight matching sets
// R6 - auto fail on any mismatch
// R7 - mismatch flag in either mode
// R8 - slot zero pattern at 0x61/0x62
// R9 - slot one pattern at 0x63/0x64
// R10 - slot two pattern at 0x65/0x66
// R11 - slot three pattern at 0x67/0x68
// R12 - parity clear zeroes both counters
// R13 - falling word parity error sets flag
// R14 - rising word parity error sets flag
// R15 - rising errors counted, saturating
// R16 - falling errors counted, saturating
// R17 - parity enable and odd/even sense
// R18 - source sends pattern words in slot order
// R19 - flags stay until cleared
`timescale 1ns/10ps
`include "iwec_cfg.svh"

module iwec_checker (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        word_valid,
	input  wire logic        word_fall,
	input  wire logic [15:0] word_data,
	input  wire logic        word_parity,
	input  wire logic [6:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             mismatch_flag,
	output logic             auto_pass_flag,
	output logic             auto_fail_flag
);
	import iwec_pkg::*;

	iwec_state_t s_q;
	iwec_state_t s_d;

	function automatic logic [15:0] slot_word(input iwec_state_t s,
		input logic [1:0] idx);
		slot_word = {s.patt[{idx, 1'b1}], s.patt[{idx, 1'b0}]};
	endfunction : slot_word

	function automatic logic [1:0] slot_index(input iwec_slot_t sl);
		case (sl)
			IWEC_SLOT0: slot_index = 2'h0;
			IWEC_SLOT1: slot_index = 2'h1;
			IWEC_SLOT2: slot_index = 2'h2;
			IWEC_SLOT3: slot_index = 2'h3;
			default:    slot_index = 2'h0;
		endcase
	endfunction : slot_index

	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		sat_inc = (v == `IWEC_CNT_CLIP) ? v : v + 8'h01;
	endfunction : sat_inc

	logic [1:0]  idx;
	logic [15:0] expect_word;
	logic        cmp_on;
	logic        auto_on;
	logic        deep;
	logic        word_bad;
	logic        set_end;
	logic        par_ok;
	logic        par_err;
	logic        wr_ctrl;
	logic        wr_pctrl;

	always_comb begin
		s_d = s_q;
		idx = slot_index(s_q.slot);
		expect_word = slot_word(s_q, idx);
		cmp_on = s_q.ctrl[`IWEC_BIT_CMP_EN];
		auto_on = s_q.ctrl[`IWEC_BIT_AUTO_EN];
		deep = s_q.ctrl[`IWEC_BIT_DEPTH];
		word_bad = word_data != expect_word;
		// two-word depth wraps after slot one
		set_end = deep ? (s_q.slot == IWEC_SLOT3)
			: (s_q.slot == IWEC_SLOT1); // R4
		// parity over data plus parity bit: odd sense means odd total
		par_ok = (^{word_data, word_parity})
			^ s_q.pctrl[`IWEC_BIT_PAR_EVEN]; // R17
		par_err = word_valid && s_q.pctrl[`IWEC_BIT_PAR_EN]
			&& !par_ok; // R17
		wr_ctrl = reg_wr && reg_addr == `IWEC_ADDR_CTRL;
		wr_pctrl = reg_wr && reg_addr == `IWEC_ADDR_PCTRL;

		// register writes
		if (wr_ctrl) begin
			s_d.ctrl[7:4] = reg_wdata[7:4];
			if (reg_wdata[`IWEC_BIT_PASS])
				s_d.ctrl[`IWEC_BIT_PASS] = 1'b1;
		end
		if (wr_pctrl)
			s_d.pctrl[7:5] = reg_wdata[7:5];
		if (reg_wr && reg_addr >= `IWEC_ADDR_S0_LO
				&& reg_addr <= `IWEC_ADDR_S3_HI)
			s_d.patt[3'(reg_addr - `IWEC_ADDR_S0_LO)] = reg_wdata; // R8 R9 R10 R11
		// upper five bits of these bytes do not exist; read back as zero
		if (reg_wr && (reg_addr == `IWEC_ADDR_S2_HI
				|| reg_addr == `IWEC_ADDR_S3_HI))
			s_d.patt[3'(reg_addr - `IWEC_ADDR_S0_LO)] =
				reg_wdata & `IWEC_HI_MASK; // R10 R11

		// clear bits act as held levels; events below win over them
		if (s_d.ctrl[`IWEC_BIT_CMP_CLR]) begin
			s_d.ctrl[2:0] = 3'h0; // R2
			s_d.good_sets = 4'h0;
		end
		if (s_d.pctrl[`IWEC_BIT_PAR_CLR]) begin
			s_d.rise_cnt = 8'h00; // R12
			s_d.fall_cnt = 8'h00; // R12
			s_d.pctrl[1:0] = 2'h0;
		end

		// pattern compare
		if (!cmp_on) begin
			s_d.slot = IWEC_SLOT0; // R1
			s_d.set_bad = 1'b0;
			s_d.good_sets = 4'h0;
		end else if (word_valid) begin // R1
			if (word_bad) begin
				s_d.ctrl[`IWEC_BIT_MISM] = 1'b1; // R7 R19
				if (auto_on)
					s_d.ctrl[`IWEC_BIT_FAIL] = 1'b1; // R6
			end
			// slots advance per word; relies on source ordering
			case (s_q.slot) // R18
				IWEC_SLOT0: s_d.slot = IWEC_SLOT1;
				IWEC_SLOT1: s_d.slot = deep ? IWEC_SLOT2 : IWEC_SLOT0;
				IWEC_SLOT2: s_d.slot = IWEC_SLOT3;
				IWEC_SLOT3: s_d.slot = IWEC_SLOT0;
				default:    s_d.slot = IWEC_SLOT0;
			endcase
			if (set_end) begin
				s_d.set_bad = 1'b0;
				if (s_q.set_bad || word_bad)
					s_d.good_sets = 4'h0;
				else if (auto_on && s_q.good_sets != `IWEC_PASS_SETS)
					s_d.good_sets = s_q.good_sets + 4'h1;
			end else begin
				s_d.set_bad = s_q.set_bad || word_bad;
			end
		end
		// eight clean sets: declare pass, drop failure indications
		if (auto_on && s_d.good_sets == `IWEC_PASS_SETS
				&& s_q.good_sets != `IWEC_PASS_SETS) begin
			s_d.ctrl[`IWEC_BIT_PASS] = 1'b1; // R5
			s_d.ctrl[`IWEC_BIT_FAIL] = 1'b0; // R3
			s_d.ctrl[`IWEC_BIT_MISM] = 1'b0; // R3
		end
		if (!auto_on)
			s_d.good_sets = 4'h0;

		// parity counting, rising = slots 0/2, falling = slots 1/3
		if (par_err) begin
			if (word_fall) begin
				s_d.fall_cnt = sat_inc(s_q.fall_cnt); // R16
				s_d.pctrl[`IWEC_BIT_FALL_ERR] = 1'b1; // R13 R19
			end else begin
				s_d.rise_cnt = sat_inc(s_q.rise_cnt); // R15
				s_d.pctrl[`IWEC_BIT_RISE_ERR] = 1'b1; // R14 R19
			end
		end
		s_d.ctrl[3] = 1'b0;
		s_d.pctrl[4:2] = 3'h0;

		// registered read data
		case (reg_addr)
			`IWEC_ADDR_CTRL:  s_d.rd_data = s_q.ctrl;
			`IWEC_ADDR_S0_LO, `IWEC_ADDR_S0_HI,
			`IWEC_ADDR_S1_LO, `IWEC_ADDR_S1_HI,
			`IWEC_ADDR_S2_LO, `IWEC_ADDR_S2_HI,
			`IWEC_ADDR_S3_LO, `IWEC_ADDR_S3_HI:
				s_d.rd_data = s_q.patt[3'(reg_addr - `IWEC_ADDR_S0_LO)];
			`IWEC_ADDR_PCTRL: s_d.rd_data = s_q.pctrl;
			`IWEC_ADDR_RCNT:  s_d.rd_data = s_q.rise_cnt;
			`IWEC_ADDR_FCNT:  s_d.rd_data = s_q.fall_cnt;
			`IWEC_ADDR_REV:   s_d.rd_data = `IWEC_REVISION;
			default:          s_d.rd_data = 8'h00;
		endcase
		if (!reg_rd)
			s_d.rd_data = s_q.rd_data;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q.ctrl <= `IWEC_RESET_BYTE;
			s_q.patt <= '0;
			s_q.pctrl <= `IWEC_RESET_BYTE;
			s_q.rise_cnt <= 8'h00;
			s_q.fall_cnt <= 8'h00;
			s_q.slot <= IWEC_SLOT0;
			s_q.good_sets <= 4'h0;
			s_q.set_bad <= 1'b0;
			s_q.rd_data <= 8'h00;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rd_data;
	assign mismatch_flag = s_q.ctrl[`IWEC_BIT_MISM];
	assign auto_pass_flag = s_q.ctrl[`IWEC_BIT_PASS];
	assign auto_fail_flag = s_q.ctrl[`IWEC_BIT_FAIL];

endmodule : iwec_checker

/* File: tb/iwec_props.sv */
// assertions on iwec_checker ports
// bound to every iwec_checker instance
`timescale 1ns/10ps
module iwec_props (
	input wire logic        clk, rst, word_valid, word_fall, word_parity,
	input wire logic [15:0] word_data,
	input wire logic [6:0]  reg_addr,
	input wire logic        reg_wr, reg_rd,
	input wire logic [7:0]  reg_wdata, reg_rdata,
	input wire logic        mismatch_flag, auto_pass_flag, auto_fail_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_clr;
		reg_wr && reg_addr == 7'h60 && reg_wdata[6] && !word_valid
		|=> !mismatch_flag && !auto_fail_flag;
	endproperty
	a_clr: assert property (p_clr) else $error("clear lost");
	property p_hold;
		mismatch_flag && !reg_wr && !word_valid |=> mismatch_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_fail;
		$rose(auto_fail_flag) |-> mismatch_flag && $past(word_valid);
	endproperty
	a_fail: assert property (p_fail) else $error("bad fail");
	property p_mism;
		$rose(mismatch_flag) |-> $past(word_valid);
	endproperty
	a_mism: assert property (p_mism) else $error("bad mism");
	property p_pass;
		$rose(auto_pass_flag) && !$past(reg_wr)
		|-> !mismatch_flag && !auto_fail_flag && $past(word_valid);
	endproperty
	a_pass: assert property (p_pass) else $error("bad pass");
	property p_unmap;
		reg_rd && reg_addr == 7'h69 |=> reg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_stand;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_stand: assert property (p_stand) else $error("rdata moved");
	property p_copy;
		reg_rd && !reg_wr && !word_valid && reg_addr == 7'h60
		|=> reg_rdata[2:0] == {auto_pass_flag, auto_fail_flag, mismatch_flag};
	endproperty
	a_copy: assert property (p_copy) else $error("flag copy");
endmodule : iwec_props
bind iwec_checker iwec_props u_props (.*);

/* File: tb/iwec_word_src.sv */
// upstream source: pattern words in slot order
// assumes controls change just after posedge
`timescale 1ns/10ps
module iwec_word_src #(parameter logic [63:0] PATT = 64'h0) (
	input wire logic  clk, run, deep, even, corrupt, bad_par,
	output logic      word_valid, word_fall, word_parity,
	output logic [15:0] word_data
);
	logic [1:0]  slot_q = 2'h0;
	logic [15:0] w;
	initial {word_valid, word_fall, word_parity, word_data} = '0;
	always @(posedge clk) begin
		w = PATT[{slot_q, 4'h0} +: 16] ^ {15'h0, corrupt};
		word_valid <= run;
		word_fall <= slot_q[0];
		// idle data toggles so a stale word never looks valid
		word_data <= run ? w : ~word_data;
		word_parity <= ^w ^ !even ^ bad_par;
		slot_q <= !run ? 2'h0 : (deep || !slot_q[0]) ? slot_q + 2'h1 : 2'h0;
	end
endmodule : iwec_word_src

/* File: tb/tb.sv */
// self-checking bench for iwec_checker
// word source on the sample side, tasks on registers
`timescale 1ns/10ps
`include "iwec_cfg.svh"
module tb;
	// slot 2/3 high bytes kept to 3 bits
	localparam logic [63:0] PATT = 64'h0571_03a4_9c3e_b25d;
	logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic        run = 0, deep = 0, even = 0, corrupt = 0, bad_par = 0;
	logic [6:0]  reg_addr = 7'h0;
	logic [7:0]  reg_wdata = 8'h0, reg_rdata;
	logic        word_valid, word_fall, word_parity;
	logic        mismatch_flag, auto_pass_flag, auto_fail_flag;
	logic [15:0] word_data;
	int          failures = 0, total_checks = 0;
	iwec_checker dut (.*);
	iwec_word_src #(.PATT(PATT)) src (.*);
	always #5 clk = ~clk;
	task chk(string n, logic [7:0] e, logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task wr(logic [6:0] a, logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask : wr
	task rd(logic [6:0] a, logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1 chk($sformatf("reg %h", a), e, reg_rdata);
	endtask : rd
	// n+1 words, first one corrupted when b
	task feed(int n, logic b);
		corrupt <= b;
		run <= 1;
		@(posedge clk);
		corrupt <= 0;
		repeat (n) @(posedge clk);
		run <= 0;
		repeat (3) @(posedge clk);
	endtask : feed
	task flags(logic [2:0] e);
		chk("flags", {5'h0, e},
			{5'h0, auto_pass_flag, auto_fail_flag, mismatch_flag});
	endtask : flags
	task t_regs;
		rd(7'h69, 8'h0);
		rd(7'h7f, `IWEC_REVISION);
		for (int i = 0; i < 8; i++) begin
			wr(7'h61 + 7'(i), PATT[i*8 +: 8]);
			rd(7'h61 + 7'(i), PATT[i*8 +: 8]);
		end
		wr(7'h66, 8'hff);
		rd(7'h66, 8'h07);
		wr(7'h68, 8'hff);
		rd(7'h68, 8'h07);
		wr(7'h66, PATT[47:40]);
		wr(7'h68, PATT[63:56]);
		wr(7'h6a, 8'h1f);
		rd(7'h6a, 8'h00);
		wr(7'h6b, 8'hff);
		rd(7'h6b, 8'h00);
		wr(7'h60, 8'h0f);
		rd(7'h60, 8'h04);
		wr(7'h60, 8'h40);
		wr(7'h60, 8'h00);
		rd(7'h60, 8'h00);
	endtask : t_regs
	task t_cmp;
		feed(3, 1);
		flags(3'h0);
		wr(7'h60, 8'h80);
		feed(11, 0);
		flags(3'h0);
		feed(3, 1);
		flags(3'h1);
		repeat (20) @(posedge clk);
		rd(7'h60, 8'h81);
		wr(7'h60, 8'hc0);
		wr(7'h60, 8'h80);
		flags(3'h0);
	endtask : t_cmp
	task t_auto;
		deep <= 1;
		wr(7'h60, 8'hb0);
		feed(3, 1);
		flags(3'h3);
		feed(27, 0);
		flags(3'h3);
		feed(3, 0);
		flags(3'h4);
		wr(7'h60, 8'h40);
		wr(7'h60, 8'h00);
		deep <= 0;
	endtask : t_auto
	task t_par;
		wr(7'h6a, 8'h80);
		bad_par <= 1;
		feed(5, 0);
		rd(7'h6b, 8'h03);
		rd(7'h6c, 8'h03);
		rd(7'h6a, 8'h83);
		wr(7'h6a, 8'hc0);
		even <= 1;
		bad_par <= 0;
		feed(3, 0);
		rd(7'h6b, 8'h03);
		wr(7'h6a, 8'h00);
		bad_par <= 1;
		feed(3, 0);
		rd(7'h6c, 8'h03);
		wr(7'h6a, 8'hc0);
		feed(519, 0);
		rd(7'h6b, 8'hff);
		rd(7'h6c, 8'hff);
		wr(7'h6a, 8'ha0);
		wr(7'h6a, 8'h80);
		rd(7'h6b, 8'h00);
		rd(7'h6a, 8'h80);
	endtask : t_par
	task final_report;
		if (failures == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		t_regs;
		t_cmp;
		t_auto;
		t_par;
		final_report;
	end
	initial begin
		#100us;
		failures++;
		final_report;
	end
endmodule : tb
